/* File: bench/file_move_instructions_test.sv */
`timescale 1ns/1ps
`default_nettype none
module file_move_instructions_test
	import fmi_pkg::*;
;
	logic              clk;
	logic              rst_n;
	logic              valid;
	logic [FMI_IW-1:0] instr;
	logic              o_zero;
	logic [FMI_DW-1:0] o_work;
	logic              o_wr;
	logic [FMI_AW-1:0] o_wr_addr;
	logic [FMI_DW-1:0] o_wr_data;
	int                fails;
	int                compares;
	fmi_core dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_valid(valid), .i_instr(instr), .o_zero(o_zero),
		.o_work(o_work), .o_wr(o_wr), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data));
	// ----------------------------------------------------------------
	// compare and drive helpers
	// ----------------------------------------------------------------
	always #2.5 clk = ~clk;
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmp8
	task automatic cmp1(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask : cmp1
	// one instruction taken; locations come up as address xor 0ah
	task automatic exec(input logic [15:0] ins, input logic [7:0] addr, input logic [7:0] data,
	                    input logic zero, input logic [7:0] work);
		valid = 1'b1;
		instr = ins;
		@(negedge clk);
		cmp1(o_wr, 1'b1, "write strobe");
		cmp8(o_wr_addr, addr, "write address");
		cmp8(o_wr_data, data, "write data");
		cmp1(o_zero, zero, "zero flag");
		cmp8(o_work, work, "working register");
	endtask : exec
	task automatic idle(input logic [15:0] ins);
		valid = (ins != 16'h0000);
		instr = ins;
		@(negedge clk);
		cmp1(o_wr, 1'b0, "no write");
	endtask : idle
	task automatic report_and_stop;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		cmp1(o_wr, 1'b0, "reset strobe");
		cmp1(o_zero, 1'b0, "reset zero");
		cmp8(o_wr_addr, 8'h00, "reset address");
		cmp8(o_work, 8'h00, "reset working");
	endtask : t_reset
	task automatic t_store_then_move;
		exec(16'h4a20, 8'h20, 8'h00, 1'b1, 8'h00);
		exec(16'h0130, 8'h30, 8'h00, 1'b1, 8'h00);
		exec(16'h5f40, 8'h40, 8'h15, 1'b0, 8'h00);
		exec(16'h4bff, 8'hff, 8'h01, 1'b0, 8'h00);
		exec(16'h5f0a, 8'h0a, 8'h15, 1'b0, 8'h15);
		exec(16'h4a50, 8'h50, 8'h15, 1'b0, 8'h15);
		exec(16'h01ff, 8'hff, 8'h15, 1'b0, 8'h15);
		idle(16'h0000);
	endtask : t_store_then_move
	task automatic t_indirect;
		exec(16'h4800, 8'h0b, 8'h09, 1'b0, 8'h15);
		exec(16'h4020, 8'h20, 8'h09, 1'b0, 8'h15);
		exec(16'h5401, 8'h01, 8'h1e, 1'b0, 8'h15);
		exec(16'h4a00, 8'h1e, 8'h15, 1'b0, 8'h15);
		exec(16'h4a08, 8'h03, 8'h15, 1'b0, 8'h15);
		idle(16'h0000);
	endtask : t_indirect
	task automatic t_refused;
		idle(16'h6130);
		idle(16'h0230);
		valid = 1'b0;
		instr = 16'h4a55;
		@(negedge clk);
		cmp1(o_wr, 1'b0, "invalid slot");
	endtask : t_refused
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		valid = 1'b0;
		instr = 16'h0000;
		fails = 0;
		compares = 0;
		repeat (2) @(negedge clk);
		t_reset();
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		t_store_then_move();
		t_indirect();
		t_refused();
		report_and_stop();
	end
	initial begin
		repeat (2000) @(posedge clk);
		fails++;
		report_and_stop();
	end
endmodule : file_move_instructions_test
`default_nettype wire

/* File: core/fmi_core.sv */
`timescale 1ns/1ps
`default_nettype none
module fmi_core
	import fmi_pkg::*;
#(
	parameter int P_DEPTH = FMI_DEPTH
)
(
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_valid,
	input  wire logic [FMI_IW-1:0] i_instr,
	output logic                   o_zero,
	output logic [FMI_DW-1:0]      o_work,
	output logic                   o_wr,
	output logic [FMI_AW-1:0]      o_wr_addr,
	output logic [FMI_DW-1:0]      o_wr_data
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (P_DEPTH != (1 << FMI_AW)) begin : g_bad_depth
		$error("data space depth must cover the whole address range");
	end

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_ff;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) rst_sync_ff <= 2'h0;
		else          rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	wire logic rst_n = rst_sync_ff[1];

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic              movp;
	logic              movw;
	logic [FMI_AW-1:0] src_raw;
	logic [FMI_AW-1:0] dst_raw;
	fmi_decode u_dec (
		.i_instr (i_instr),
		.i_valid (i_valid && rst_n),
		.o_movp  (movp),
		.o_movw  (movw),
		.o_src   (src_raw),
		.o_dst   (dst_raw)
	);

	// ----------------------------------------------------------------
	// data space
	// ----------------------------------------------------------------
	logic [FMI_DW-1:0] mem_ff [P_DEPTH];
	logic              zero_ff;

	function automatic logic [FMI_AW-1:0] fmi_resolve(input logic [FMI_AW-1:0] a,
	                                                  input logic [FMI_DW-1:0] p0,
	                                                  input logic [FMI_DW-1:0] p1);
		if (a == FMI_ADDR_INDF0)      fmi_resolve = p0;
		else if (a == FMI_ADDR_INDF1) fmi_resolve = p1;
		else                          fmi_resolve = a;
	endfunction : fmi_resolve

	wire logic [FMI_DW-1:0] fsr0 = mem_ff[FMI_ADDR_FSR0];
	wire logic [FMI_DW-1:0] fsr1 = mem_ff[FMI_ADDR_FSR1];
	wire logic [FMI_AW-1:0] src  = fmi_resolve(src_raw, fsr0, fsr1);
	wire logic [FMI_AW-1:0] dst  = fmi_resolve(dst_raw, fsr0, fsr1);
	// working register is an ordinary location of the array
	wire logic [FMI_DW-1:0] src_byte = mem_ff[src];
	wire logic [FMI_DW-1:0] work_byte = mem_ff[FMI_ADDR_WORK];
	wire logic              do_wr = movp || movw;
	wire logic [FMI_DW-1:0] nxt_data = movp ? src_byte : work_byte;
	wire logic              nxt_zero = movp ? (src_byte == FMI_ZERO_BYTE) : zero_ff;

	// one write port; a location loads only when it is the resolved target
	// reset pattern is address xor 0ah: bytes differ, working register comes up zero
	for (genvar g = 0; g < P_DEPTH; g++) begin : g_loc
		wire logic hit = do_wr && (dst == FMI_AW'(g));
		always_ff @(posedge i_clk or negedge rst_n) begin
			if (!rst_n)   mem_ff[g] <= FMI_DW'(g) ^ FMI_ADDR_WORK;
			else if (hit) mem_ff[g] <= nxt_data;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) zero_ff <= 1'b0;
		else        zero_ff <= nxt_zero;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	logic              wr_ff;
	logic [FMI_AW-1:0] wr_addr_ff;
	logic [FMI_DW-1:0] wr_data_ff;
	logic [FMI_DW-1:0] work_ff;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ff      <= 1'b0;
			wr_addr_ff <= FMI_RST_BYTE;
			wr_data_ff <= FMI_RST_BYTE;
			work_ff    <= FMI_RST_BYTE;
		end else begin
			wr_ff      <= do_wr;
			wr_addr_ff <= do_wr ? dst : wr_addr_ff;
			wr_data_ff <= do_wr ? nxt_data : wr_data_ff;
			work_ff    <= (do_wr && dst == FMI_ADDR_WORK) ? nxt_data : work_byte;
		end
	end
	assign o_zero    = zero_ff;
	assign o_work    = work_ff;
	assign o_wr      = wr_ff;
	assign o_wr_addr = wr_addr_ff;
	assign o_wr_data = wr_data_ff;

	// ----------------------------------------------------------------
	// checks: copy and zero flag
	// ----------------------------------------------------------------
	chk_movp_copy: assert property (@(posedge i_clk) disable iff (!rst_n)
		movp |=> (o_wr && o_wr_data == $past(src_byte)))
		else $error("move to file did not copy source");
	chk_movp_zero: assert property (@(posedge i_clk) disable iff (!rst_n)
		movp |=> (o_zero == ($past(src_byte) == FMI_ZERO_BYTE)))
		else $error("zero flag wrong after move");
	chk_zero_set: assert property (@(posedge i_clk) disable iff (!rst_n)
		(movp && src_byte == FMI_ZERO_BYTE) |=> o_zero)
		else $error("zero flag not set by zero byte");
	chk_zero_clear: assert property (@(posedge i_clk) disable iff (!rst_n)
		(movp && src_byte != FMI_ZERO_BYTE) |=> !o_zero)
		else $error("zero flag not cleared by nonzero byte");
	chk_mem_copy: assert property (@(posedge i_clk) disable iff (!rst_n)
		movp |=> mem_ff[$past(dst)] == $past(src_byte))
		else $error("destination location not loaded");
	chk_refuse_op: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_valid && !movp && !movw) |=> !o_wr)
		else $error("unknown opcode wrote a location");

	// ----------------------------------------------------------------
	// checks: addressing
	// ----------------------------------------------------------------
	chk_dst_full: assert property (@(posedge i_clk) disable iff (!rst_n)
		(do_wr && dst_raw != FMI_ADDR_INDF0 && dst_raw != FMI_ADDR_INDF1) |=> o_wr_addr == $past(dst_raw))
		else $error("destination address mismatch");
	chk_dst_reach: assert property (@(posedge i_clk) disable iff (!rst_n)
		do_wr |=> o_wr_addr == $past(dst))
		else $error("resolved destination not reported");
	chk_out_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
		!do_wr |=> ($stable(o_wr_addr) && $stable(o_wr_data)))
		else $error("write outputs changed without a write");
	chk_src_range: assert property (@(posedge i_clk) disable iff (!rst_n)
		movp |-> src_raw <= FMI_AW'(FMI_P_MAX))
		else $error("source out of low area");
	chk_src_plain: assert property (@(posedge i_clk) disable iff (!rst_n)
		(movp && src_raw != FMI_ADDR_INDF0 && src_raw != FMI_ADDR_INDF1) |-> src == src_raw)
		else $error("direct source moved away from its field");

	// ----------------------------------------------------------------
	// checks: working register
	// ----------------------------------------------------------------
	chk_work_dst: assert property (@(posedge i_clk) disable iff (!rst_n)
		(movp && dst == FMI_ADDR_WORK) |=> o_work == $past(src_byte))
		else $error("working register not written");
	chk_work_src: assert property (@(posedge i_clk) disable iff (!rst_n)
		(movp && src == FMI_ADDR_WORK) |=> o_wr_data == $past(o_work))
		else $error("working register not used as source");
	chk_work_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
		!(do_wr && dst == FMI_ADDR_WORK) |=> $stable(o_work))
		else $error("working register changed without a write");
	chk_work_mirror: assert property (@(posedge i_clk) disable iff (!rst_n)
		o_work == work_byte)
		else $error("working register output out of step");

	// ----------------------------------------------------------------
	// checks: indirect access
	// ----------------------------------------------------------------
	chk_indirect: assert property (@(posedge i_clk) disable iff (!rst_n)
		(do_wr && dst_raw == FMI_ADDR_INDF0) |=> o_wr_addr == $past(fsr0))
		else $error("indirect destination not resolved");
	chk_indirect1: assert property (@(posedge i_clk) disable iff (!rst_n)
		(do_wr && dst_raw == FMI_ADDR_INDF1) |=> o_wr_addr == $past(fsr1))
		else $error("second indirect destination not resolved");
	chk_src_ind0: assert property (@(posedge i_clk) disable iff (!rst_n)
		(movp && src_raw == FMI_ADDR_INDF0) |-> src == fsr0)
		else $error("indirect source not resolved");
	chk_src_ind1: assert property (@(posedge i_clk) disable iff (!rst_n)
		(movp && src_raw == FMI_ADDR_INDF1) |-> src == fsr1)
		else $error("second indirect source not resolved");

	// ----------------------------------------------------------------
	// checks: working store
	// ----------------------------------------------------------------
	chk_movw_data: assert property (@(posedge i_clk) disable iff (!rst_n)
		movw |=> (o_wr && o_wr_data == $past(work_byte)))
		else $error("working store wrong data");
	chk_movw_status: assert property (@(posedge i_clk) disable iff (!rst_n)
		movw |=> $stable(o_zero))
		else $error("status changed by working store");
	chk_movw_work: assert property (@(posedge i_clk) disable iff (!rst_n)
		(movw && dst == FMI_ADDR_WORK) |=> o_work == $past(work_byte))
		else $error("working store onto itself changed it");
	chk_zero_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
		!movp |=> $stable(o_zero))
		else $error("zero flag changed without a move");
	chk_wr_pulse: assert property (@(posedge i_clk) disable iff (!rst_n)
		!do_wr |=> !o_wr)
		else $error("write strobe without an instruction");
endmodule : fmi_core
`default_nettype wire

/* File: core/fmi_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module fmi_decode
	import fmi_pkg::*;
(
	input  wire logic [FMI_IW-1:0] i_instr,
	input  wire logic              i_valid,
	output logic                   o_movp,
	output logic                   o_movw,
	output logic [FMI_AW-1:0]      o_src,
	output logic [FMI_AW-1:0]      o_dst
);
	// ----------------------------------------------------------------
	// field split
	// ----------------------------------------------------------------
	wire logic [2:0] op3 = i_instr[FMI_IW-1:FMI_MOVP_OP_LSB];
	wire logic [7:0] op8 = i_instr[FMI_IW-1:FMI_MOVW_OP_LSB];
	wire logic [FMI_PW-1:0] pfld = i_instr[FMI_MOVP_OP_LSB-1:FMI_MOVP_P_LSB];

	assign o_movp = i_valid && (op3 == FMI_OP_MOVP);
	assign o_movw = i_valid && (op8 == FMI_OP_MOVW);
	// source limited to 00h..1fh
	assign o_src  = {{(FMI_AW-FMI_PW){1'b0}}, pfld};
	assign o_dst  = i_instr[FMI_AW-1:0];
endmodule : fmi_decode
`default_nettype wire

/* File: core/fmi_pkg.sv */
package fmi_pkg;
	// ----------------------------------------------------------------
	// instruction encoding
	// ----------------------------------------------------------------
	localparam int          FMI_IW             = 16;
	localparam int          FMI_DW             = 8;
	localparam int          FMI_AW             = 8;
	localparam int          FMI_PW             = 5;
	localparam logic [2:0]  FMI_OP_MOVP        = 3'h2;
	localparam logic [7:0]  FMI_OP_MOVW        = 8'h01;
	localparam int          FMI_MOVP_OP_LSB    = 13;
	localparam int          FMI_MOVP_P_LSB     = 8;
	localparam int          FMI_MOVW_OP_LSB    = 8;
	// ----------------------------------------------------------------
	// data space locations
	// ----------------------------------------------------------------
	localparam logic [7:0]  FMI_ADDR_INDF0     = 8'h00;
	localparam logic [7:0]  FMI_ADDR_FSR0      = 8'h01;
	localparam logic [7:0]  FMI_ADDR_INDF1     = 8'h08;
	localparam logic [7:0]  FMI_ADDR_FSR1      = 8'h09;
	localparam logic [7:0]  FMI_ADDR_WORK      = 8'h0a;
	localparam logic [7:0]  FMI_RST_BYTE       = 8'h00;
	localparam logic [7:0]  FMI_ZERO_BYTE      = 8'h00;
	localparam int          FMI_DEPTH          = 256;
	localparam int          FMI_P_MAX          = 31;
endpackage : fmi_pkg
